// ### rtl/aeso_pkg.sv
// shared constants for the angle encoder serial link, pwm, fuses and controller registers
package aeso_pkg;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int ANGLE_W        = 12;
  localparam int WORD_W         = 18;
  localparam int CHAIN_EXTRA    = 1;
  localparam int SLOT_W         = WORD_W + CHAIN_EXTRA;
  localparam int FUSE_W         = 54;
  localparam int FUSE_USER_W    = 21;
  localparam int FUSE_HI_W      = FUSE_W - 32;
  localparam int MODE0_POS      = 51;
  localparam int MODE1_POS      = 50;
  localparam logic [1:0] QUAD_MODE_CODE = 2'h1;
  // pwm: 1 us steps, 1025 steps a period
  localparam int PWM_STEP_NS    = 1000;
  localparam int PWM_STEP_CYC   = (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] STEP_LAST = 7'(PWM_STEP_CYC - 1);
  localparam int PWM_PERIOD_STEPS = 1025;
  localparam logic [10:0] PWM_LAST = 11'(PWM_PERIOD_STEPS - 1);
  // serial clock no faster than 1 MHz
  localparam int SCLK_MIN_PERIOD_NS = 1000;
  localparam int SCLK_HALF_CYC  = (SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // pin order in the device synchroniser
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_PROG = 2;
  localparam int PIN_BURN = 3;
  // controller register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_IRQ_ST  = 8'h08;
  localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN  = 8'h10;
  localparam logic [7:0] REG_FUSE_LO = 8'h14;
  localparam logic [7:0] REG_FUSE_HI = 8'h18;
  localparam logic [7:0] REG_DATA0   = 8'h20;
  localparam int CTRL_READ = 0;
  localparam int CTRL_LOAD = 1;
  localparam int CTRL_BURN = 2;
  localparam int CTRL_CHAIN_LSB = 4;
  localparam int CHAIN_W = 4;
  localparam logic [CHAIN_W-1:0] CHAIN_RST = 4'h0;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
  localparam logic [31:0] FUSE_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] JOB_READ = 3'h1;
  localparam logic [2:0] JOB_LOAD = 3'h2;
  localparam logic [2:0] JOB_BURN = 3'h4;
endpackage

// ### rtl/aeso_link_if.sv
// serial link pins between the encoder and its host controller
`timescale 1ns/1ps
`default_nettype none
interface aeso_link_if;
  logic chipSelectLow;
  logic sclk;
  logic progData;
  logic fuseBurnVoltage;
  logic dout;
  logic doutOeN;
  logic doutLevel;
  logic pwm;
  logic fieldStrongerFlagOeN;
  logic fieldWeakerFlagOeN;
  logic fieldStrongerFlag;
  logic fieldWeakerFlag;
  // tri-state data reads low when released; flags are open drain with pull-up
  assign doutLevel = doutOeN ? 1'b0 : dout;
  assign fieldStrongerFlag = fieldStrongerFlagOeN;
  assign fieldWeakerFlag = fieldWeakerFlagOeN;
  modport device (input chipSelectLow, sclk, progData, fuseBurnVoltage,
                  output dout, doutOeN, pwm, fieldStrongerFlagOeN, fieldWeakerFlagOeN);
  modport host (output chipSelectLow, sclk, progData, fuseBurnVoltage,
                input doutLevel, pwm, fieldStrongerFlag, fieldWeakerFlag);
endinterface
`default_nettype wire

// ### rtl/aeso_pin_sync.sv
// two-flop synchroniser with edge pulses for a group of pins
`timescale 1ns/1ps
`default_nettype none
module aeso_pin_sync #(
  parameter int               WIDTH    = 1,
  parameter logic [WIDTH-1:0] IDLE_LVL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } aeso_sync_t;
  aeso_sync_t r;
  aeso_sync_t n;
  always_comb begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= {IDLE_LVL, IDLE_LVL, IDLE_LVL};
    end else begin
      r <= n;
    end
  end
  assign level = r.s2;
  assign rise = r.s2 & ~r.s3;
  assign fall = ~r.s2 & r.s3;
endmodule // aeso_pin_sync
`default_nettype wire

// ### rtl/aeso_device.sv
// encoder end: serial angle readout, daisy chain, pwm, magnet flags and fuse loading
`timescale 1ns/1ps
`default_nettype none
module aeso_device
  import aeso_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  aeso_link_if.device             link,
  input  wire logic [ANGLE_W-1:0] angle,
  input  wire logic               sensorReady,
  input  wire logic               magnetCloser,
  input  wire logic               magnetFarther,
  input  wire logic [FUSE_W-1:0]  fuseArray,
  output logic      [FUSE_W-1:0]  fuseBurnData,
  output logic                    fuseBurnStrobe,
  output logic                    progModeActive,
  output logic                    quadratureMode
);
  typedef enum logic [2:0] {
    DEV_IDLE  = 3'b001,
    DEV_SHIFT = 3'b010,
    DEV_PROG  = 3'b100
  } aeso_dev_st_t;

  typedef struct packed {
    aeso_dev_st_t      st;
    logic [SLOT_W-1:0] shiftReg;
    logic              dout;
    logic              doutOeN;
    logic [FUSE_W-1:0] fuseShift;
    logic [5:0]        burnCnt;
    logic              burnStrobe;
    logic [FUSE_W-1:0] burnData;
    logic [FUSE_W-1:0] fuseActive;
    logic              fuseLoaded;
    logic              quadMode;
    logic [6:0]        stepDiv;
    logic [10:0]       pwmStep;
    logic [10:0]       pwmHigh;
    logic              pwm;
    logic              strongerOeN;
    logic              weakerOeN;
  } aeso_dev_t;

  localparam logic [5:0] BURN_LAST = 6'(FUSE_W - 1);

  // pwm high steps for an angle: 1 + angle/4, 1..1024
  function automatic logic [10:0] pwm_high(input logic [ANGLE_W-1:0] ang);
    return {1'b0, ang[ANGLE_W-1:2]} + 11'h001;
  endfunction

  aeso_dev_t        r;
  aeso_dev_t        n;
  logic [3:0]       pinLvl;
  logic [3:0]       pinRise;
  logic [3:0]       pinFall;
  logic [WORD_W-1:0] frame;
  logic             csEnter;

  // chip select idles high, so its stages start high and no false edge follows reset
  aeso_pin_sync #(.WIDTH(4), .IDLE_LVL(4'h1)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pins     ({link.fuseBurnVoltage, link.progData, link.sclk, link.chipSelectLow}),
    .level    (pinLvl),
    .rise     (pinRise),
    .fall     (pinFall)
  );

  // angle msb first, then ready, two spare zeros, stronger, weaker, even parity
  always_comb begin
    frame = '0;
    frame[WORD_W-1:WORD_W-ANGLE_W] = angle;
    frame[5] = sensorReady;
    frame[2] = magnetCloser;
    frame[1] = magnetFarther;
    frame[0] = ^frame[WORD_W-1:1];
  end

  // cs rising edge with prog high and sclk low arms programming
  assign csEnter = pinRise[PIN_CS] && pinLvl[PIN_PROG] && !pinLvl[PIN_SCLK];

  always_comb begin
    n = r;
    n.burnStrobe = 1'b0;
    // fuse contents are captured once after reset, so a burn shows after power-up
    if (!r.fuseLoaded) begin
      n.fuseActive = fuseArray;
      n.fuseLoaded = 1'b1;
      // first period after reset already follows the angle
      n.pwmHigh = pwm_high(angle);
    end
    // mode bits come from the captured copy, never the live array
    n.quadMode = r.fuseLoaded &&
                 ({r.fuseActive[MODE1_POS], r.fuseActive[MODE0_POS]} == QUAD_MODE_CODE);
    n.strongerOeN = ~magnetCloser;
    n.weakerOeN = ~magnetFarther;

    // pwm: 1 us step tick, 1025-step period, high for 1 + angle/4 steps
    if (r.stepDiv == STEP_LAST) begin
      n.stepDiv = '0;
      if (r.pwmStep == PWM_LAST) begin
        n.pwmStep = '0;
        n.pwmHigh = pwm_high(angle);
      end else begin
        n.pwmStep = r.pwmStep + 11'h001;
      end
    end else begin
      n.stepDiv = r.stepDiv + 7'h01;
    end
    n.pwm = r.pwmStep < r.pwmHigh;

    case (r.st)
      DEV_IDLE: begin
        // data pin released until a frame starts
        n.doutOeN = 1'b1;
        if (csEnter) begin
          n.st = DEV_PROG;
        end else if (pinFall[PIN_CS]) begin
          // whole frame latched at once, plus the chain spacer bit
          n.shiftReg = {frame, 1'b0};
          n.doutOeN = 1'b0;
          n.st = DEV_SHIFT;
        end
      end
      DEV_SHIFT: begin
        if (pinRise[PIN_CS]) begin
          // chip select rising ends the frame or enters programming
          n.doutOeN = 1'b1;
          n.st = csEnter ? DEV_PROG : DEV_IDLE;
        end else if (pinRise[PIN_SCLK]) begin
          // downstream stream enters behind our own bits
          n.shiftReg = {r.shiftReg[SLOT_W-2:0], pinLvl[PIN_PROG]};
        end
      end
      DEV_PROG: begin
        // no way out except reset
        n.doutOeN = 1'b1;
        if (pinRise[PIN_SCLK]) begin
          if (pinLvl[PIN_BURN]) begin
            if (r.burnCnt == BURN_LAST) begin
              n.burnCnt = '0;
              // loaded pattern handed over on the last burn pulse
              n.burnStrobe = 1'b1;
              n.burnData = r.fuseShift;
            end else begin
              n.burnCnt = r.burnCnt + 6'h01;
            end
          end else begin
            n.fuseShift = {r.fuseShift[FUSE_W-2:0], pinLvl[PIN_PROG]};
          end
        end
      end
      default: begin
        n.st = DEV_IDLE;
      end
    endcase
    n.dout = n.shiftReg[SLOT_W-1];
  end

  // reset releases the data pin and both flags
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= DEV_IDLE;
      r.doutOeN <= 1'b1;
      r.strongerOeN <= 1'b1;
      r.weakerOeN <= 1'b1;
      r.pwmHigh <= 11'h001;
    end else begin
      r <= n;
    end
  end

  // every pin and output comes straight from the state register
  assign link.dout = r.dout;
  assign link.doutOeN = r.doutOeN;
  assign link.pwm = r.pwm;
  assign link.fieldStrongerFlagOeN = r.strongerOeN;
  assign link.fieldWeakerFlagOeN = r.weakerOeN;
  assign fuseBurnData = r.burnData;
  assign fuseBurnStrobe = r.burnStrobe;
  assign progModeActive = r.st[2];
  assign quadratureMode = r.quadMode;
endmodule // aeso_device
`default_nettype wire

// ### rtl/aeso_host.sv
// host controller: axi4-lite registers driving encoder readout, fuse load and burn
`timescale 1ns/1ps
`default_nettype none
module aeso_host
  import aeso_pkg::*;
#(
  parameter int MAX_DEV = 4
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  aeso_link_if.host        link,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001, H_SETUP = 5'b00010, H_LOW = 5'b00100, H_HIGH = 5'b01000, H_END = 5'b10000
  } aeso_host_st_t;

  typedef struct packed {
    aeso_host_st_t st;
    logic [2:0] job;
    logic [1:0] setupStep;
    logic [6:0] halfCnt;
    logic [7:0] bitCnt;
    logic [7:0] bitTotal;
    logic [4:0] slotPos;
    logic [3:0] devIdx;
    logic [WORD_W-1:0] rx;
    logic [MAX_DEV-1:0][WORD_W-1:0] words;
    logic cs, sclk, prog, burn, progEntered;
    logic [CHAIN_W-1:0] chain;
    logic [31:0] fuseLo;
    logic [FUSE_HI_W-1:0] fuseHi;
    logic [IRQ_W-1:0] irqSt, irqEn;
    logic irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } aeso_host_t;

  localparam logic [6:0] HALF_LAST = 7'(SCLK_HALF_CYC - 1);
  localparam logic [7:0] FUSE_LAST = 8'(FUSE_W - 1);

  aeso_host_t r;
  aeso_host_t n;
  logic       doutLvl;
  logic       tick;
  logic [FUSE_W-1:0] fuseVec;
  logic [7:0] fuseIdx;
  logic [IRQ_W-1:0] evt;
  logic [IRQ_W-1:0] clr;
  logic [5:0] dIdx;
  logic [31:0] mrg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  aeso_pin_sync #(.WIDTH(1)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pins     (link.doutLevel),
    .level    (doutLvl),
    .rise     (),
    .fall     ()
  );

  assign tick = r.halfCnt == HALF_LAST;
  assign fuseVec = {r.fuseHi, r.fuseLo};
  assign fuseIdx = FUSE_LAST - r.bitCnt;

  always_comb begin
    n = r;
    evt = '0;
    clr = '0;
    dIdx = '0;
    mrg = '0;
    n.halfCnt = (r.st == H_IDLE || tick) ? 7'h00 : r.halfCnt + 7'h01;
    case (r.st)
      H_IDLE: begin
        n.bitCnt = '0;
        n.slotPos = '0;
        n.devIdx = '0;
      end
      H_SETUP: if (tick) begin
        n.setupStep = r.setupStep + 2'h1;
        if (r.job == JOB_LOAD && r.setupStep == 2'h0) begin
          n.prog = 1'b1;
        end else if (r.job == JOB_LOAD && r.setupStep == 2'h1) begin
          n.cs = 1'b1;
          n.progEntered = 1'b1;
        end else begin
          n.st = H_LOW;
        end
      end
      H_LOW: begin
        if (r.job == JOB_LOAD) begin
          n.prog = fuseVec[fuseIdx[5:0]];
        end
        if (tick) begin
          n.sclk = 1'b1;
          n.st = H_HIGH;
          if (r.job == JOB_READ) begin
            n.slotPos = (r.slotPos == 5'(SLOT_W - 1)) ? 5'h00 : r.slotPos + 5'h01;
            if (r.slotPos < 5'(WORD_W)) begin
              n.rx = {r.rx[WORD_W-2:0], doutLvl};
            end
            if (r.slotPos == 5'(WORD_W - 1)) begin
              n.words[r.devIdx] = {r.rx[WORD_W-2:0], doutLvl};
              n.devIdx = r.devIdx + 4'h1;
            end
          end
        end
      end
      H_HIGH: if (tick) begin
        n.sclk = 1'b0;
        n.bitCnt = r.bitCnt + 8'h01;
        n.st = (r.bitCnt + 8'h01 == r.bitTotal) ? H_END : H_LOW;
      end
      H_END: if (tick) begin
        n.cs = 1'b1;
        n.prog = 1'b0;
        n.burn = 1'b0;
        evt = r.job;
        n.st = H_IDLE;
      end
      default: n.st = H_IDLE;
    endcase

    // axi write: address and data taken together
    n.awready = 1'b0;
    n.wready = 1'b0;
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_wvalid && !r.bvalid && !r.awready) begin
      n.awready = 1'b1;
      n.wready = 1'b1;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (s_axi_awaddr)
        REG_CTRL: begin
          if (s_axi_wstrb[0]) begin
            n.chain = s_axi_wdata[CTRL_CHAIN_LSB +: CHAIN_W];
          end
          if (s_axi_wstrb[0] && r.st == H_IDLE) begin
            n.setupStep = '0;
            n.st = H_SETUP;
            if (s_axi_wdata[CTRL_READ]) begin
              n.job = JOB_READ;
              n.cs = 1'b0;
              n.bitTotal = 8'(SLOT_W) * (8'(s_axi_wdata[CTRL_CHAIN_LSB +: CHAIN_W]) + 8'h01);
            end else if (s_axi_wdata[CTRL_LOAD]) begin
              n.job = JOB_LOAD;
              n.cs = 1'b0;
              n.bitTotal = 8'(FUSE_W);
            end else if (s_axi_wdata[CTRL_BURN]) begin
              n.job = JOB_BURN;
              n.burn = 1'b1;
              n.bitTotal = 8'(FUSE_W);
            end else begin
              n.st = H_IDLE;
            end
          end
        end
        REG_IRQ_CLR: clr = s_axi_wstrb[0] ? s_axi_wdata[IRQ_W-1:0] : '0;
        REG_IRQ_EN: begin
          mrg = merge({29'h0, r.irqEn}, s_axi_wdata, s_axi_wstrb);
          n.irqEn = mrg[IRQ_W-1:0];
        end
        REG_FUSE_LO: n.fuseLo = merge(r.fuseLo, s_axi_wdata, s_axi_wstrb);
        REG_FUSE_HI: begin
          mrg = merge({10'h0, r.fuseHi}, s_axi_wdata, s_axi_wstrb);
          n.fuseHi = mrg[FUSE_HI_W-1:0];
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // sticky events, a new event beats a clear
    n.irqSt = (r.irqSt & ~clr) | evt;
    n.irq = |(n.irqSt & n.irqEn);

    // axi read
    n.arready = 1'b0;
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid && !r.arready) begin
      n.arready = 1'b1;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      dIdx = s_axi_araddr[7:2] - REG_DATA0[7:2];
      case (s_axi_araddr)
        REG_CTRL: n.rdata[CTRL_CHAIN_LSB +: CHAIN_W] = r.chain;
        REG_STATUS: n.rdata[1:0] = {r.progEntered, r.st != H_IDLE};
        REG_IRQ_ST: n.rdata[IRQ_W-1:0] = r.irqSt;
        REG_IRQ_EN: n.rdata[IRQ_W-1:0] = r.irqEn;
        REG_FUSE_LO: n.rdata = r.fuseLo;
        REG_FUSE_HI: n.rdata[FUSE_HI_W-1:0] = r.fuseHi;
        default: begin
          if (s_axi_araddr >= REG_DATA0 && s_axi_araddr[1:0] == 2'h0 && int'(dIdx) < MAX_DEV) begin
            n.rdata[WORD_W-1:0] = r.words[dIdx];
          end else begin
            n.rresp = RESP_SLVERR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= H_IDLE;
      r.cs <= 1'b1;
      r.chain <= CHAIN_RST;
      r.irqEn <= IRQ_EN_RST;
      r.fuseLo <= FUSE_RST;
      r.fuseHi <= FUSE_RST[FUSE_HI_W-1:0];
    end else begin
      r <= n;
    end
  end

  assign link.chipSelectLow = r.cs;
  assign link.sclk = r.sclk;
  assign link.progData = r.prog;
  assign link.fuseBurnVoltage = r.burn;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign irq = r.irq;
endmodule // aeso_host
`default_nettype wire

// ### verif/aeso_assertions.sv
// pin-level checks on the link between the host controller and the encoder end
`timescale 1ns/1ps
`default_nettype none
module aeso_assertions
  import aeso_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic chipSelectLow,
  input wire logic sclk,
  input wire logic progData,
  input wire logic fuseBurnVoltage,
  input wire logic doutOeN,
  input wire logic pwm
);
  logic [6:0]  hiCnt;
  logic [6:0]  loCnt;
  logic [7:0]  riseCnt;
  logic [5:0]  burnCnt;
  logic [16:0] pwmCnt;
  logic [3:0]  csHiCnt;
  logic        sclkQ;
  logic        sclkUp;
  assign sclkUp = sclk & ~sclkQ;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {hiCnt, loCnt, riseCnt, burnCnt, pwmCnt, csHiCnt, sclkQ} <= '0;
    end else begin
      sclkQ   <= sclk;
      hiCnt   <= sclk ? hiCnt + 7'h01 : 7'h00;
      loCnt   <= sclk ? 7'h00 : loCnt + {6'h00, loCnt != 7'h7F};
      riseCnt <= chipSelectLow ? 8'h00 : riseCnt + {7'h00, sclkUp};
      burnCnt <= fuseBurnVoltage ? burnCnt + {5'h00, sclkUp} : 6'h00;
      pwmCnt  <= pwm ? pwmCnt + 17'h00001 : 17'h00000;
      csHiCnt <= chipSelectLow ? csHiCnt + {3'h0, csHiCnt != 4'hF} : 4'h0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence sclkHeldLow;
    !sclk [*8];
  endsequence
  sequence doutTaken;
    ##[1:8] !doutOeN;
  endsequence
  chk_cs_setup: assert property ($fell(chipSelectLow) |-> sclkHeldLow)
    else $error("serial clock moved right after chip select fell");
  chk_dout_drive: assert property ($fell(chipSelectLow) |-> doutTaken)
    else $error("data output not driven after chip select fell");
  chk_dout_release: assert property (csHiCnt == 4'h8 |-> doutOeN)
    else $error("data output still driven with chip select high");
  chk_sclk_high: assert property ($fell(sclk) |-> hiCnt == 7'(SCLK_HALF_CYC))
    else $error("serial clock high half has wrong length");
  chk_sclk_low: assert property ($rose(sclk) |-> loCnt >= 7'(SCLK_HALF_CYC))
    else $error("serial clock low half too short");
  chk_frame_len: assert property ($rose(chipSelectLow) |-> (riseCnt % 8'h13) == 8'h00)
    else $error("frame is not a whole number of device slots");
  chk_prog_entry: assert property ($rose(chipSelectLow) && progData |-> !sclk && !fuseBurnVoltage)
    else $error("programming entry with serial clock high");
  chk_burn_mode: assert property ($rose(fuseBurnVoltage) |-> chipSelectLow && !sclk)
    else $error("burn voltage raised outside programming mode");
  chk_burn_count: assert property ($fell(fuseBurnVoltage) |-> burnCnt == 6'h36)
    else $error("burn did not apply the full clock pulse count");
  chk_pwm_high: assert property ($fell(pwm) |->
      pwmCnt >= 17'h00064 && pwmCnt <= 17'h19000 && (pwmCnt % 17'h00064) == 17'h00000)
    else $error("pwm high time is not a whole number of steps");
endmodule // aeso_assertions
`default_nettype wire

// ### verif/tb.sv
// bench: host controller and encoder end joined over the link, driven over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module tb
  import aeso_pkg::*;
;
  logic               core_clk = 1'h0;
  logic               arst_n = 1'h0;
  logic [ANGLE_W-1:0] angle = 12'h013;
  logic               magCloser = 1'h0;
  logic               magFarther = 1'h0;
  logic               ready = 1'h1;
  logic [FUSE_W-1:0]  fuseArray = '0;
  logic [FUSE_W-1:0]  burnData;
  logic [FUSE_W-1:0]  burnSeen = '0;
  logic               burnHit = 1'h0;
  logic               burnStrobe, progMode, quadMode, irq, irqExp;
  logic [7:0]         awaddr = 8'h00;
  logic [7:0]         araddr = 8'h00;
  logic [31:0]        wdata = 32'h0;
  logic [31:0]        rdata, rd, lo, hi;
  logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp, rsp;
  logic [11:0]        a;
  logic [3:0]         ch;
  logic [7:0]         rstRegs [3] = '{REG_CTRL, REG_IRQ_EN, REG_FUSE_LO};
  int                 n_errors = 0, num_checks = 0, cyc = 0, i, k;

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  aeso_link_if lnk ();
  aeso_device u_aeso_device (.core_clk(core_clk), .arst_n(arst_n), .link(lnk.device), .angle(angle),
    .sensorReady(ready), .magnetCloser(magCloser), .magnetFarther(magFarther), .fuseArray(fuseArray),
    .fuseBurnData(burnData), .fuseBurnStrobe(burnStrobe), .progModeActive(progMode), .quadratureMode(quadMode));
  aeso_host u_aeso_host (.core_clk(core_clk), .arst_n(arst_n), .link(lnk.host), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  aeso_assertions u_aeso_assertions (.core_clk(core_clk), .arst_n(arst_n), .chipSelectLow(lnk.chipSelectLow),
    .sclk(lnk.sclk), .progData(lnk.progData), .fuseBurnVoltage(lnk.fuseBurnVoltage), .doutOeN(lnk.doutOeN),
    .pwm(lnk.pwm));

  always @(posedge core_clk) begin
    if (burnStrobe === 1'h1) begin
      burnSeen <= burnData;
      burnHit  <= 1'h1;
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  function automatic logic [30:0] exp_lead(input logic [11:0] ang, input logic rdy, input logic cl, input logic fa);
    return {14'h0, ang, rdy, 2'h0, cl, fa};
  endfunction

  function automatic int pwm_cycles(input logic [11:0] ang);
    return (1 + int'(ang[11:2])) * PWM_STEP_CYC;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    rsp = bresp;
  endtask

  task automatic rd32(input logic [7:0] ad);
    @(posedge core_clk);
    araddr  <= ad;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    rd = rdata;
    rsp = rresp;
  endtask

  // poll the sticky status bit, check the interrupt line, then clear it
  task automatic wait_st(input int b);
    rd = 32'h0;
    for (int n = 0; n < 3000 && rd[b] !== 1'h1; n++) rd32(REG_IRQ_ST);
    check(rd[b], 1'h1);
    check(irq, irqExp);
    wr(REG_IRQ_CLR, 32'h1 << b);
    rd32(REG_IRQ_ST);
    check({irq, rd[b]}, 2'h0);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(40));
    repeat (3) @(posedge core_clk);
    arst_n <= 1'h1;
    for (k = 0; k < 300 && lnk.pwm !== 1'h1; k++) @(posedge core_clk);
    for (k = 0; k < 2000 && lnk.pwm === 1'h1; k++) @(posedge core_clk);
    check(k, pwm_cycles(angle));
    foreach (rstRegs[j]) begin
      rd32(rstRegs[j]);
      check(rd, 32'h0);
    end
    rd32(8'hFC);
    check(rsp, RESP_SLVERR);
    wr(8'hFC, 32'h1);
    check(rsp, RESP_SLVERR);
    for (i = 0; i < 6; i++) begin
      a = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($urandom);
      ch = 4'(i % 2);
      irqExp = (i != 3);
      angle <= a;
      magCloser <= i[0];
      magFarther <= ~i[0] & i[1];
      ready <= (i != 2);
      wr(REG_IRQ_EN, {29'h0, {3{irqExp}}});
      wr(REG_CTRL, {24'h0, ch, 4'h1});
      wait_st(0);
      rd32(REG_DATA0);
      check(rd[31:1], exp_lead(a, i != 2, i[0], ~i[0] & i[1]));
      check(^rd[17:0], 1'h0);
      if (ch[0]) begin
        rd32(REG_DATA0 + 8'h04);
        check(rd, 32'h0);
      end
      check({lnk.fieldStrongerFlag, lnk.fieldWeakerFlag}, {~magCloser, ~magFarther});
    end
    lo = $urandom;
    hi = ($urandom & 32'h0033FFFF) | 32'h00080000;
    irqExp = 1'h1;
    wr(REG_FUSE_LO, lo);
    wr(REG_FUSE_HI, hi);
    wr(REG_CTRL, 32'h2);
    wait_st(1);
    rd32(REG_STATUS);
    check({progMode, rd[1]}, 2'h3);
    wr(REG_CTRL, 32'h4);
    wait_st(2);
    check({burnHit, burnSeen}, {1'h1, hi[21:0], lo});
    check({progMode, quadMode}, 2'h2);
    fuseArray <= burnSeen;
    arst_n <= 1'h0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge core_clk);
    check({progMode, quadMode}, 2'h1);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
